// ---- src/dacsw_core.sv ----
// Purpose: serial write front end and mode control of a 16-bit DAC
// Assumes: serial pins sampled by sys_clk, well slower than sys_clk
// Notes:   arst_n stands in for the power-on reset
`timescale 1ns/10ps
`include "dacsw_defs.svh"
module dacsw_core #(
   parameter int PD_EXIT_CYC = `DACSW_PD_EXIT_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        clk_en,
   input  wire logic        frame_sel_n,
   input  wire logic        ser_clk,
   input  wire logic        ser_data,
   output logic [15:0]      dac_code,
   output logic             pwrdn_sel_hi,
   output logic             pwrdn_sel_lo,
   output logic             amp_enable,
   output logic             out_1k_gnd,
   output logic             out_100k_gnd,
   output logic             out_valid,
   output logic             update_pulse,
   output logic             abort_pulse
);
   localparam int CW = $clog2(PD_EXIT_CYC + 1);

   typedef enum {
      IDLE,
      SHIFT,
      DONE
   } dacsw_fsm_e;

   typedef struct packed {
      dacsw_fsm_e         fsm;
      logic               sclk_d;
      logic               sel_d;
      logic               data_d;
      logic [17:0]        shreg;
      logic [4:0]         bitcnt;
      logic [15:0]        code;
      dacsw_pkg::dacsw_mode_e mode;
      logic               amp_on;
      logic               r1k;
      logic               r100k;
      logic               valid;
      logic [CW-1:0]      wake;
      logic               upd;
      logic               abt;
   } dacsw_core_s;

   dacsw_core_s st;
   dacsw_core_s next_st;
   logic        sclk_s;
   logic        sel_s;
   logic        data_s;
   logic        sclk_fall;
   logic        sel_fall;
   logic        sel_rise;
   logic [17:0] shifted;

   // Pin synchronisers
   dacsw_sync3 #(.INIT(1'b0)) u_sync_clk (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .clk_en  (clk_en),
      .din     (ser_clk),
      .dout    (sclk_s)
   );
   dacsw_sync3 #(.INIT(1'b1)) u_sync_sel (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .clk_en  (clk_en),
      .din     (frame_sel_n),
      .dout    (sel_s)
   );
   dacsw_sync3 #(.INIT(1'b0)) u_sync_dat (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .clk_en  (clk_en),
      .din     (ser_data),
      .dout    (data_s)
   );

   // Edge detection on filtered pins
   assign sclk_fall = st.sclk_d & ~sclk_s;
   assign sel_fall  = st.sel_d & ~sel_s;
   assign sel_rise  = ~st.sel_d & sel_s;
   assign shifted   = {st.shreg[16:0], st.data_d};

   // Frame sequencing, execution and output stage control
   always_comb begin
      next_st        = st;
      next_st.sclk_d = sclk_s;
      next_st.sel_d  = sel_s;
      next_st.data_d = data_s;
      next_st.upd    = 1'b0;
      next_st.abt    = 1'b0;
      case (st.fsm)
         IDLE: begin
            if (sel_fall) begin
               next_st.fsm    = SHIFT;
               next_st.shreg  = 18'h00000;
               next_st.bitcnt = 5'h00;
            end
         end
         SHIFT: begin
            if (sel_s) begin
               // Early rise throws the frame away
               next_st.fsm    = IDLE;
               next_st.shreg  = 18'h00000;
               next_st.bitcnt = 5'h00;
               next_st.abt    = 1'b1;
            end else if (sclk_fall) begin
               next_st.shreg  = shifted;
               next_st.bitcnt = st.bitcnt + 5'h01;
               if (st.bitcnt + 5'h01 == `DACSW_EXEC_EDGE) begin
                  next_st.code = shifted[15:0];
                  next_st.mode = dacsw_pkg::dacsw_mode_e'(shifted[17:16]);
                  next_st.upd  = 1'b1;
                  next_st.fsm  = DONE;
               end
            end
         end
         DONE: begin
            // Trailing bits ignored until the select rises
            if (sel_s) begin
               next_st.fsm = IDLE;
            end
         end
         default: begin
            next_st.fsm = IDLE;
         end
      endcase
      // Output network from the active mode
      next_st.amp_on = (next_st.mode == dacsw_pkg::DACSW_NORMAL);
      next_st.r1k    = (next_st.mode == dacsw_pkg::DACSW_PD_1K);
      next_st.r100k  = (next_st.mode == dacsw_pkg::DACSW_PD_100K);
      // Wake timer after leaving power-down
      if (!next_st.amp_on) begin
         next_st.wake  = CW'(PD_EXIT_CYC);
         next_st.valid = 1'b0;
      end else if (st.wake != '0) begin
         next_st.wake  = st.wake - CW'(1);
         next_st.valid = 1'b0;
      end else begin
         next_st.valid = 1'b1;
      end
   end

   // State register; reset gives zero code and normal mode
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st        <= '0;
         st.fsm    <= IDLE;
         st.sel_d  <= 1'b1;
         st.code   <= `DACSW_CODE_RESET;
         st.mode   <= dacsw_pkg::dacsw_mode_e'(`DACSW_MODE_RESET);
         st.amp_on <= 1'b1;
         st.valid  <= 1'b1;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   // Outputs straight from state
   assign dac_code     = st.code;
   assign pwrdn_sel_hi = st.mode[1];
   assign pwrdn_sel_lo = st.mode[0];
   assign amp_enable   = st.amp_on;
   assign out_1k_gnd   = st.r1k;
   assign out_100k_gnd = st.r100k;
   assign out_valid    = st.valid;
   assign update_pulse = st.upd;
   assign abort_pulse  = st.abt;

   // Aborted frame leaves code unchanged
   abort_keeps_code_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      st.abt |-> st.code == $past(st.code))
      else $error("abort changed code");

   // Aborted frame leaves mode unchanged
   abort_keeps_mode_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      st.abt |-> st.mode == $past(st.mode))
      else $error("abort changed mode");

   // Early select rise aborts the frame
   early_rise_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (clk_en && st.fsm == SHIFT && sel_rise) |=> st.abt && st.fsm == IDLE && !st.upd)
      else $error("early rise not aborted");

   // Shift register clears on abort
   abort_clear_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      st.abt |-> st.shreg == 18'h00000 && st.fsm == IDLE)
      else $error("shifter not cleared");

   // Abort pulse lasts one cycle
   abort_single_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (clk_en && st.abt) |=> !st.abt)
      else $error("abort pulse too long");

   // Falling select arms an empty count
   frame_arm_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (clk_en && st.fsm == IDLE && sel_fall) |=> st.fsm == SHIFT && st.bitcnt == 5'h00)
      else $error("frame not armed");

   // Each serial clock fall in the shift state, select still low, shifts one bit
   shift_step_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (clk_en && st.fsm == SHIFT && !sel_s && sclk_fall) |=> st.shreg == $past(shifted))
      else $error("bit not shifted");

   // Update loads the shifted code
   update_load_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (clk_en && next_st.upd) |=> st.code == $past(shifted[15:0]))
      else $error("update code wrong");

   // Update takes the first two bits as mode
   update_mode_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (clk_en && next_st.upd) |=> st.mode == $past(shifted[17:16]))
      else $error("update mode wrong");

   // Update happens only on the eighteenth edge
   exec_edge_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      st.upd |-> st.bitcnt == 5'd18)
      else $error("update off count");

   // Update comes straight from the shift state
   update_source_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(st.upd) |-> st.fsm == DONE && $past(st.fsm) == SHIFT)
      else $error("update from wrong state");

   // Update pulse lasts one cycle
   update_single_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (clk_en && st.upd) |=> !st.upd)
      else $error("update pulse too long");

   // Count never passes the execute edge
   count_limit_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      st.bitcnt <= `DACSW_EXEC_EDGE)
      else $error("bit count overrun");

   // Done state waits for the select rise
   done_holds_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (clk_en && st.fsm == DONE && !sel_s) |=> st.fsm == DONE && !st.upd && !st.abt)
      else $error("done state left early");

   // Done state ignores clock edges
   tail_ignored_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (st.fsm == DONE && !st.upd) |-> $stable(st.code))
      else $error("tail bits used");

   // Code stable outside updates
   code_hold_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      !st.upd |-> $stable(st.code) or !$past(arst_n))
      else $error("code moved");

   // Output network matches mode
   mode_decode_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (st.r1k == (st.mode == dacsw_pkg::DACSW_PD_1K)) &&
      (st.r100k == (st.mode == dacsw_pkg::DACSW_PD_100K)))
      else $error("mode decode wrong");

   // Open output mode drives nothing
   open_output_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (st.mode == dacsw_pkg::DACSW_PD_HIZ) |-> !st.amp_on && !st.r1k && !st.r100k)
      else $error("open mode drives output");

   // Amplifier off in power-down
   amp_off_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (st.mode != dacsw_pkg::DACSW_NORMAL) |-> !st.amp_on && !st.valid)
      else $error("amp on in powerdown");

   // Normal mode uses the amplifier only
   normal_amp_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (st.mode == dacsw_pkg::DACSW_NORMAL) |-> st.amp_on && !st.r1k && !st.r100k)
      else $error("normal mode path wrong");

   // At most one output path at a time
   one_path_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      $onehot0({st.amp_on, st.r1k, st.r100k}))
      else $error("two output paths on");

   // Wake not valid immediately after power-down exit
   wake_delay_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      ($rose(st.amp_on) && PD_EXIT_CYC > 1) |-> !st.valid)
      else $error("valid too early");

   // Valid only once the wake count has run out
   valid_needs_a : assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      st.valid |-> st.amp_on && st.wake == '0)
      else $error("valid before wake done");
endmodule : dacsw_core

// ---- src/dacsw_defs.svh ----
// Purpose: constants for the serial write and power-down block
// Assumes: system clock of 50 MHz
// Notes:   frame layout is mode bits first, then sixteen code bits
`ifndef DACSW_DEFS_SVH
`define DACSW_DEFS_SVH

`define DACSW_FRAME_BITS     24
`define DACSW_EXEC_EDGE      5'd18
`define DACSW_CODE_RESET     16'h0000
`define DACSW_MODE_RESET     2'h0
`define DACSW_CLK_MHZ        50
`define DACSW_PD_EXIT_US     50
`define DACSW_PD_EXIT_CYC    (`DACSW_PD_EXIT_US * `DACSW_CLK_MHZ)

`endif

// ---- src/dacsw_pkg.sv ----
// Purpose: types for the serial write and power-down block
// Assumes: nothing beyond the constants header
// Notes:   mode codes follow the two select bits
package dacsw_pkg;
   typedef enum logic [1:0] {
      DACSW_NORMAL  = 2'h0,
      DACSW_PD_1K   = 2'h1,
      DACSW_PD_100K = 2'h2,
      DACSW_PD_HIZ  = 2'h3
   } dacsw_mode_e;
endpackage : dacsw_pkg

// ---- src/dacsw_sync3.sv ----
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to sys_clk
// Notes:   output changes only once stages two and three agree
`timescale 1ns/10ps
module dacsw_sync3 #(
   parameter logic INIT = 1'b0
) (
   input  wire logic sys_clk,
   input  wire logic arst_n,
   input  wire logic clk_en,
   input  wire logic din,
   output logic      dout
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } dacsw_sync_s;

   dacsw_sync_s st;
   dacsw_sync_s next_st;

   // Shift chain and agreement filter
   always_comb begin
      next_st    = st;
      next_st.s1 = din;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if (st.s2 == st.s3) begin
         next_st.q = st.s3;
      end
   end

   // State register
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= {INIT, INIT, INIT, INIT};
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign dout = st.q;
endmodule : dacsw_sync3

// ---- tb/dacsw_host.sv ----
// Purpose: serial master model driving the frame pins
// Assumes: link clock period of 160 ns, idle low
// Notes:   data changes on the rising link edge
`timescale 1ns/10ps
module dacsw_host (
   output logic frame_sel_n,
   output logic ser_clk,
   output logic ser_data
);
   // Idle pins at time zero
   initial begin
      frame_sel_n = 1'b1;
      ser_clk     = 1'b0;
      ser_data    = 1'b0;
   end

   // One frame of nf falling edges, first bit first
   task automatic send(input logic [23:0] w, input int nf);
      #7 frame_sel_n = 1'b0;
      for (int i = 0; i < nf; i++) begin
         #40 ser_clk = 1'b1;
         ser_data = w[23 - i];
         #80 ser_clk = 1'b0;
         #40;
      end
      #40 frame_sel_n = 1'b1;
      ser_data = ~ser_data; // Released line shows no stale value
      #100;
   endtask : send
endmodule : dacsw_host

// ---- tb/dac_serial_write_powerdown_tb_top.sv ----
// Purpose: self-checking bench for the serial write block
// Assumes: exit delay shortened to eight cycles
// Notes:   don't-care tail bits are sent as ones
`timescale 1ns/10ps
module dac_serial_write_powerdown_tb_top;
   localparam int PD_EXIT = 8;
   logic        sys_clk, arst_n, clk_en, frame_sel_n, ser_clk, ser_data;
   logic [15:0] dac_code;
   logic        pwrdn_sel_hi, pwrdn_sel_lo, amp_enable, out_1k_gnd, out_100k_gnd;
   logic        out_valid, update_pulse, abort_pulse, valid_q;
   int          bad_count, n_compared, cyc;
   int          n_upd, n_abt, t_upd, t_val, u, a;

   dacsw_core #(.PD_EXIT_CYC(PD_EXIT)) dut_u (
      .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
      .frame_sel_n(frame_sel_n), .ser_clk(ser_clk), .ser_data(ser_data),
      .dac_code(dac_code), .pwrdn_sel_hi(pwrdn_sel_hi), .pwrdn_sel_lo(pwrdn_sel_lo),
      .amp_enable(amp_enable), .out_1k_gnd(out_1k_gnd), .out_100k_gnd(out_100k_gnd),
      .out_valid(out_valid), .update_pulse(update_pulse), .abort_pulse(abort_pulse));
   dacsw_host host_u (.frame_sel_n(frame_sel_n), .ser_clk(ser_clk), .ser_data(ser_data));

   // System clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Pulse counters, exit timing and hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      valid_q <= out_valid;
      if (update_pulse === 1'b1) begin
         n_upd <= n_upd + 1;
         t_upd <= cyc;
      end
      if (abort_pulse === 1'b1) n_abt <= n_abt + 1;
      if (out_valid === 1'b1 && valid_q === 1'b0) t_val <= cyc;
      if (cyc == 20000) begin
         bad_count++;
         conclude();
      end
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Stored code and mode decode
   task automatic st(input logic [15:0] code, input logic [1:0] m);
      chk("code", dac_code, code);
      chk("mode", {14'h0, pwrdn_sel_hi, pwrdn_sel_lo}, {14'h0, m});
      chk("amp", {15'h0, amp_enable}, {15'h0, m == 2'h0});
      chk("r1k", {15'h0, out_1k_gnd}, {15'h0, m == 2'h1});
      chk("r100k", {15'h0, out_100k_gnd}, {15'h0, m == 2'h2});
   endtask : st

   // Send one frame and let it settle
   task automatic fr(input logic [1:0] m, input logic [15:0] code, input int nf);
      u = n_upd;
      a = n_abt;
      host_u.send({m, code, 6'h3F}, nf);
      repeat (20) @(posedge sys_clk);
   endtask : fr

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude

   // Main sequence
   initial begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      st(16'h0000, 2'h0);
      chk("valid", {15'h0, out_valid}, 16'h0001);
      $display("test reset done");
      for (int m = 0; m < 4; m++) begin
         fr(2'(m), 16'hA5C3, 24);
         st(16'hA5C3, 2'(m));
         chk("upd", 16'(n_upd), 16'(u + 1));
         chk("valid", {15'h0, out_valid}, {15'h0, m == 0});
      end
      $display("test modes done");
      fr(2'h0, 16'h8001, 18);
      st(16'h8001, 2'h0);
      chk("upd", 16'(n_upd), 16'(u + 1));
      chk("exit", 16'(t_val - t_upd), 16'(PD_EXIT));
      chk("valid", {15'h0, out_valid}, 16'h0001);
      $display("test short frame done");
      fr(2'h3, 16'h1234, 17);
      st(16'h8001, 2'h0);
      chk("abort", 16'(n_abt), 16'(a + 1));
      chk("upd", 16'(n_upd), 16'(u));
      fr(2'h2, 16'h7FFE, 24);
      st(16'h7FFE, 2'h2);
      clk_en <= 1'b0;
      fr(2'h1, 16'h0F0F, 24);
      clk_en <= 1'b1;
      st(16'h7FFE, 2'h2);
      chk("upd", 16'(n_upd), 16'(u));
      $display("test abort done");
      conclude();
   end
endmodule : dac_serial_write_powerdown_tb_top
